// ==== sqr_pkg.sv ====
// sqr_pkg: constants and carrier types for the sequencer status/control register group
`default_nettype none
package sqr_pkg;
   // register pointers seen by the serial front end
   localparam logic [7:0] OFF_LOG_FIRST = 8'h20;
   localparam logic [7:0] OFF_LOG_LAST = 8'h25;
   localparam logic [7:0] OFF_STATUS = 8'h26;
   localparam logic [7:0] OFF_VERSION = 8'h27;
   localparam logic [7:0] OFF_RAIL_HIGH = 8'h28;
   localparam logic [7:0] OFF_RAIL_LOW = 8'h29;
   localparam logic [7:0] OFF_LOCK = 8'h2E;
   localparam logic [7:0] OFF_RESTART = 8'h2F;
   localparam logic [7:0] OFF_WADDR_LOW = 8'h30;
   localparam logic [7:0] OFF_WADDR_HIGH = 8'h31;
   localparam logic [7:0] OFF_WDATA_LOW = 8'h32;
   localparam logic [7:0] OFF_WDATA_HIGH = 8'h33;
   localparam logic [7:0] OFF_FOREIGN_LAST = 8'h1F;
   // status and lock bit positions
   localparam int ST_BUS_FAULT = 7;
   localparam int ST_RAIL_FAULT = 6;
   localparam int ST_STORED_LOG = 5;
   localparam int ST_FW_FAULT = 4;
   localparam int ST_PARAM_FAULT = 3;
   localparam int LOCK_BIT = 0;
   // bus fault type codes
   localparam logic [1:0] FT_NONE = 2'h0;
   localparam logic [1:0] FT_BAD_ADDR = 2'h1;
   localparam logic [1:0] FT_READ = 2'h2;
   localparam logic [1:0] FT_WRITE = 2'h3;
   // restart command codes
   localparam logic [7:0] CMD_RESTART = 8'h00;
   localparam logic [7:0] CMD_SHUTDOWN = 8'hC0;
   // revision nibbles, arbitrary values
   localparam logic [3:0] REV_MAJOR = 4'h1;
   localparam logic [3:0] REV_MINOR = 4'h0;
   // reset values
   localparam logic [7:0] LOCK_RESET = 8'h00;
   localparam logic [15:0] WINDOW_RESET = 16'h0000;
   // stored error log window in internal memory
   localparam logic [15:0] LOG_BASE = 16'h1000;
   localparam logic [15:0] LOG_BYTES = 16'h0030;
   // timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int RESTART_DELAY_PS = 50000000;
   localparam int RESTART_CYCLES = (RESTART_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RCNT_W = 12;

   typedef struct packed {
      logic start;
      logic [7:0] offset;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sqr_acc_s;

   typedef struct packed {
      logic [7:0] rail_fault;
      logic fw_corrupt;
      logic param_invalid;
      logic log_nonempty;
      logic log_empty;
      logic [7:0] log_byte;
   } sqr_evt_s;
endpackage : sqr_pkg
`default_nettype wire

// ==== sqr_regs.sv ====
// sqr_regs: status, fault mask, restart, lock and memory window registers
`default_nettype none
module sqr_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // byte access from the serial front end
   input wire sqr_pkg::sqr_acc_s acc,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // events from the sequencing engine
   input wire sqr_pkg::sqr_evt_s evt,
   // configuration memory port
   output logic [15:0] cfg_addr,
   output logic [15:0] cfg_wdata,
   output logic cfg_wr,
   output logic cfg_rd,
   input wire logic cfg_rvalid,
   input wire logic [15:0] cfg_rdata,
   output logic log_window_sel,
   // system control
   output logic restart_req,
   output logic shutdown_req,
   output logic config_locked,
   output logic device_idle,
   output logic use_last_good
);

   localparam int RCNT_W_L = sqr_pkg::RCNT_W;

   typedef struct packed {
      logic bus_flag;
      logic [1:0] bus_type;
      logic rail_flag;
      logic stored_log;
      logic log_caught;
      logic fw_flag;
      logic param_flag;
      logic fw_hold;
      logic param_hold;
      logic [7:0] rail_mask;
      logic [7:0] lock;
      logic [15:0] waddr;
      logic [15:0] wdata;
      logic [7:0] ptr;
      logic [2:0] nbytes;
      logic [2:0] limit;
      logic [7:0] rd_data;
      logic rd_valid;
      logic [RCNT_W_L-1:0] rcnt;
      logic rarm;
      logic restart;
      logic shutdown;
      logic cfg_wr;
      logic cfg_rd;
   } sqr_state_s;

   sqr_state_s st_reg;
   sqr_state_s st_next;

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic is_ours(input logic [7:0] p);
      is_ours = (p <= sqr_pkg::OFF_FOREIGN_LAST) ||
                (p >= sqr_pkg::OFF_LOG_FIRST && p <= sqr_pkg::OFF_RAIL_LOW) ||
                (p >= sqr_pkg::OFF_LOCK && p <= sqr_pkg::OFF_WDATA_HIGH);
   endfunction : is_ours

   // bytes a transfer may span from its first pointer
   function automatic logic [2:0] span(input logic [7:0] p);
      logic [7:0] d;
      d = sqr_pkg::OFF_LOG_LAST - p + 8'h01;
      if (p <= sqr_pkg::OFF_FOREIGN_LAST) begin
         span = 3'h7;
      end else if (p >= sqr_pkg::OFF_LOG_FIRST && p <= sqr_pkg::OFF_LOG_LAST) begin
         span = d[2:0];
      end else if (p == sqr_pkg::OFF_RAIL_HIGH || p == sqr_pkg::OFF_WADDR_LOW ||
                   p == sqr_pkg::OFF_WDATA_LOW) begin
         span = 3'h2;
      end else begin
         span = 3'h1;
      end
   endfunction : span

   // two-byte pairs wrap inside the pair
   function automatic logic [7:0] advance(input logic [7:0] p);
      if (p == sqr_pkg::OFF_RAIL_HIGH || p == sqr_pkg::OFF_RAIL_LOW ||
          p >= sqr_pkg::OFF_WADDR_LOW) begin
         advance = p ^ 8'h01;
      end else begin
         advance = p + 8'h01;
      end
   endfunction : advance

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [7:0] status;
      logic st_rd;
      logic over;
      logic [7:0] rb;
      st_next = st_reg;
      status = 8'h00;
      st_rd = 1'b0;
      over = 1'b0;
      rb = 8'h00;
      st_next.rd_valid = 1'b0;
      st_next.restart = 1'b0;
      st_next.shutdown = 1'b0;
      st_next.cfg_wr = 1'b0;
      st_next.cfg_rd = 1'b0;

      status[sqr_pkg::ST_BUS_FAULT] = st_reg.bus_flag;
      status[sqr_pkg::ST_RAIL_FAULT] = st_reg.rail_flag;
      status[sqr_pkg::ST_STORED_LOG] = st_reg.stored_log;
      status[sqr_pkg::ST_FW_FAULT] = st_reg.fw_flag;
      status[sqr_pkg::ST_PARAM_FAULT] = st_reg.param_flag;
      status[1:0] = st_reg.bus_type;

      // stored-log flag taken once, the first edge after reset release
      if (!st_reg.log_caught) begin
         st_next.stored_log = evt.log_nonempty;
         st_next.log_caught = 1'b1;
      end

      if (acc.start) begin
         st_next.ptr = acc.offset;
         st_next.nbytes = 3'h0;
         st_next.limit = span(acc.offset);
      end else if (acc.rd || acc.wr) begin
         over = st_reg.nbytes >= st_reg.limit;
         st_next.ptr = advance(st_reg.ptr);
         if (!over) begin
            st_next.nbytes = st_reg.nbytes + 3'h1;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // reads: data out and clear-on-read
      if (acc.rd && !acc.start) begin
         case (st_reg.ptr)
            sqr_pkg::OFF_STATUS: begin
               rb = status;
               st_rd = !over;
            end
            sqr_pkg::OFF_VERSION: rb = {sqr_pkg::REV_MAJOR, sqr_pkg::REV_MINOR};
            sqr_pkg::OFF_RAIL_HIGH: rb = 8'h00;
            sqr_pkg::OFF_RAIL_LOW: begin
               rb = st_reg.rail_mask;
               if (!over) begin
                  st_next.rail_mask = 8'h00;
               end
            end
            sqr_pkg::OFF_LOCK: rb = st_reg.lock;
            sqr_pkg::OFF_WADDR_LOW: rb = st_reg.waddr[7:0];
            sqr_pkg::OFF_WADDR_HIGH: rb = st_reg.waddr[15:8];
            sqr_pkg::OFF_WDATA_LOW: rb = st_reg.wdata[7:0];
            sqr_pkg::OFF_WDATA_HIGH: rb = st_reg.wdata[15:8];
            default: begin
               // empty log reads back as the null alarm
               if (st_reg.ptr >= sqr_pkg::OFF_LOG_FIRST && st_reg.ptr <= sqr_pkg::OFF_LOG_LAST &&
                   !evt.log_empty) begin
                  rb = evt.log_byte;
               end else begin
                  rb = 8'h00;
               end
            end
         endcase
         st_next.rd_data = over ? 8'h00 : rb;
         st_next.rd_valid = 1'b1;
      end

      if (st_rd) begin
         st_next.bus_flag = 1'b0;
         st_next.bus_type = sqr_pkg::FT_NONE;
         st_next.rail_flag = 1'b0;
         st_next.fw_flag = 1'b0;
         st_next.param_flag = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////
      // writes
      if (acc.wr && !acc.start && !over) begin
         case (st_reg.ptr)
            sqr_pkg::OFF_LOCK: st_next.lock = acc.wdata;
            sqr_pkg::OFF_RESTART: begin
               if (acc.wdata == sqr_pkg::CMD_RESTART) begin
                  st_next.rarm = 1'b1;
                  st_next.rcnt = '0;
               end else if (acc.wdata == sqr_pkg::CMD_SHUTDOWN) begin
                  st_next.shutdown = 1'b1;
               end
               // any other code is dropped
            end
            sqr_pkg::OFF_WADDR_LOW: st_next.waddr[7:0] = acc.wdata;
            sqr_pkg::OFF_WADDR_HIGH: begin
               st_next.waddr[15:8] = acc.wdata;
               st_next.cfg_rd = 1'b1;
            end
            sqr_pkg::OFF_WDATA_LOW: st_next.wdata[7:0] = acc.wdata;
            sqr_pkg::OFF_WDATA_HIGH: begin
               st_next.wdata[15:8] = acc.wdata;
               st_next.cfg_wr = !st_reg.lock[sqr_pkg::LOCK_BIT];
            end
            default: st_next.lock = st_reg.lock;
         endcase
      end
      // fetched words land after the address is complete
      if (cfg_rvalid) begin
         st_next.wdata = cfg_rdata;
      end

      // restart waits so the acknowledge can finish
      if (st_reg.rarm) begin
         if (st_reg.rcnt == RCNT_W_L'(sqr_pkg::RESTART_CYCLES - 1)) begin
            st_next.rarm = 1'b0;
            st_next.restart = 1'b1;
         end else begin
            st_next.rcnt = st_reg.rcnt + RCNT_W_L'(1);
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // event flags: a set in the clearing cycle wins
      if (acc.start && !is_ours(acc.offset)) begin
         st_next.bus_flag = 1'b1;
         st_next.bus_type = sqr_pkg::FT_BAD_ADDR;
      end else if (acc.rd && !acc.start &&
                   (over || st_reg.ptr == sqr_pkg::OFF_RESTART)) begin
         st_next.bus_flag = 1'b1;
         st_next.bus_type = sqr_pkg::FT_READ;
      end else if (acc.wr && !acc.start &&
                   (over || (st_reg.ptr >= sqr_pkg::OFF_LOG_FIRST &&
                             st_reg.ptr <= sqr_pkg::OFF_RAIL_LOW) ||
                    (st_reg.ptr == sqr_pkg::OFF_WDATA_HIGH &&
                     st_reg.lock[sqr_pkg::LOCK_BIT]))) begin
         st_next.bus_flag = 1'b1;
         st_next.bus_type = sqr_pkg::FT_WRITE;
      end
      if (|evt.rail_fault) begin
         st_next.rail_flag = 1'b1;
         st_next.rail_mask = st_next.rail_mask | evt.rail_fault;
      end
      if (evt.fw_corrupt) begin
         st_next.fw_flag = 1'b1;
         st_next.fw_hold = 1'b1;
      end
      if (evt.param_invalid) begin
         st_next.param_flag = 1'b1;
         st_next.param_hold = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.lock <= sqr_pkg::LOCK_RESET;
         st_reg.waddr <= sqr_pkg::WINDOW_RESET;
         st_reg.wdata <= sqr_pkg::WINDOW_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs from flops; log_window_sel is decoded from the window address
   assign rd_data = st_reg.rd_data;
   assign rd_valid = st_reg.rd_valid;
   assign cfg_addr = st_reg.waddr;
   assign cfg_wdata = st_reg.wdata;
   assign cfg_wr = st_reg.cfg_wr;
   assign cfg_rd = st_reg.cfg_rd;
   assign restart_req = st_reg.restart;
   assign shutdown_req = st_reg.shutdown;
   assign config_locked = st_reg.lock[sqr_pkg::LOCK_BIT];
   assign device_idle = st_reg.fw_hold;
   assign use_last_good = st_reg.param_hold;
   assign log_window_sel = (st_reg.waddr >= sqr_pkg::LOG_BASE) &&
      (st_reg.waddr < sqr_pkg::LOG_BASE + sqr_pkg::LOG_BYTES);

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   logic [RCNT_W_L:0] arm_age;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arm_age <= '0;
      end else if (st_next.rarm && !st_reg.rarm) begin
         arm_age <= '0;
      end else if (st_reg.rarm) begin
         arm_age <= arm_age + (RCNT_W_L + 1)'(1);
      end
   end

   status_clear_a: assert property (
      acc.rd && !acc.start && st_reg.ptr == sqr_pkg::OFF_STATUS && st_reg.nbytes == 3'h0 &&
      evt.rail_fault == 8'h00 && !evt.fw_corrupt && !evt.param_invalid |=>
      !st_reg.rail_flag && !st_reg.fw_flag && !st_reg.param_flag)
      else $error("status read left a flag set");
   stored_log_hold_a: assert property (
      st_reg.log_caught |=> $stable(st_reg.stored_log))
      else $error("stored-log flag changed after reset");
   bad_address_a: assert property (
      acc.start && !is_ours(acc.offset) |=> st_reg.bus_flag &&
      st_reg.bus_type == sqr_pkg::FT_BAD_ADDR)
      else $error("invalid address not flagged");
   rail_fault_set_a: assert property (
      evt.rail_fault != 8'h00 |=> st_reg.rail_flag && ((st_reg.rail_mask & $past(evt.rail_fault))
      == $past(evt.rail_fault)))
      else $error("rail fault not recorded");
   restart_delay_a: assert property (
      restart_req |-> arm_age == (RCNT_W_L + 1)'(sqr_pkg::RESTART_CYCLES))
      else $error("restart pulse at wrong delay");
   shutdown_cmd_a: assert property (
      acc.wr && !acc.start && st_reg.ptr == sqr_pkg::OFF_RESTART && st_reg.nbytes == 3'h0 &&
      acc.wdata == sqr_pkg::CMD_SHUTDOWN |=> shutdown_req ##1 !shutdown_req)
      else $error("shutdown not issued once");
   other_cmd_a: assert property (
      acc.wr && !acc.start && st_reg.ptr == sqr_pkg::OFF_RESTART && !st_reg.rarm &&
      acc.wdata != sqr_pkg::CMD_SHUTDOWN && acc.wdata != sqr_pkg::CMD_RESTART |=>
      !shutdown_req && !st_reg.rarm)
      else $error("unknown restart code acted");
   window_address_a: assert property (
      acc.start && acc.offset == sqr_pkg::OFF_WADDR_LOW ##1 acc.wr && !acc.start
      ##1 acc.wr && !acc.start |=> cfg_addr == {$past(acc.wdata), $past(acc.wdata, 2)})
      else $error("two-byte address load wrong");
   fw_idle_a: assert property (
      evt.fw_corrupt |=> st_reg.fw_flag ##1 device_idle [*3])
      else $error("firmware fault not held");

   restart_seen_c: cover property (restart_req);
   locked_write_c: cover property (acc.wr && st_reg.ptr == sqr_pkg::OFF_WDATA_HIGH &&
      config_locked);
   read_fault_c: cover property (st_reg.bus_type == sqr_pkg::FT_READ);
endmodule : sqr_regs
`default_nettype wire

// ==== sqr_host_model.sv ====
// sqr_host_model: bus host that reaches the register group one byte at a time
`default_nettype none
module sqr_host_model (
   // clock
   input wire logic core_clk,
   // byte access toward the register group
   output var sqr_pkg::sqr_acc_s acc,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial acc = '0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // each task starts just after an edge and returns just after the edge that took it
   task automatic put_start(input logic [7:0] off);
      acc.start = 1'b1;
      acc.offset = off;
      @(posedge core_clk);
      #1;
      acc.start = 1'b0;
      // a released pointer must not keep its old value
      acc.offset = ~off;
   endtask : put_start

   task automatic put_wr(input logic [7:0] data);
      acc.wr = 1'b1;
      acc.wdata = data;
      @(posedge core_clk);
      #1;
      acc.wr = 1'b0;
      acc.wdata = ~data;
   endtask : put_wr

   task automatic get_rd(output logic [7:0] data);
      acc.rd = 1'b1;
      @(posedge core_clk);
      #1;
      acc.rd = 1'b0;
      // one spare cycle for a late answer; one still missing reads as a mismatch, not a hang
      if (rd_valid !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
   endtask : get_rd

   ////////////////////////////////////////////////////////////////////////////////////////////
   // two-byte write from one start, low byte first
   // strobe held up across both bytes, so no signal is set twice in one step
   task automatic put_word(input logic [7:0] off, input logic [15:0] word);
      put_start(off);
      acc.wr = 1'b1;
      acc.wdata = word[7:0];
      @(posedge core_clk);
      #1;
      acc.wdata = word[15:8];
      @(posedge core_clk);
      #1;
      acc.wr = 1'b0;
      acc.wdata = ~word[15:8];
   endtask : put_word

   // two-byte read from one start, first byte lands in the low half
   task automatic get_pair(input logic [7:0] off, output logic [15:0] pair);
      put_start(off);
      acc.rd = 1'b1;
      @(posedge core_clk);
      #1;
      pair[7:0] = (rd_valid === 1'b1) ? rd_data : 8'hXX;
      @(posedge core_clk);
      #1;
      acc.rd = 1'b0;
      pair[15:8] = (rd_valid === 1'b1) ? rd_data : 8'hXX;
   endtask : get_pair
endmodule : sqr_host_model
`default_nettype wire

// ==== testbench.sv ====
// testbench: stimulus, reference model and checks for the status/control register group
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] FAULT_OFF [4] = '{8'h2A, 8'h26, 8'h2F, 8'h27};
   localparam logic [7:0] FAULT_ST [4] = '{8'h81, 8'h83, 8'h82, 8'h82};
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   sqr_pkg::sqr_acc_s acc;
   sqr_pkg::sqr_evt_s evt = '0;
   logic [7:0] rd_data;
   logic rd_valid, cfg_wr, cfg_rd, log_window_sel, restart_req, shutdown_req;
   logic config_locked, device_idle, use_last_good;
   logic [15:0] cfg_addr, cfg_wdata, last_w;
   logic cfg_rvalid = 1'b0;
   logic [15:0] cfg_rdata = 16'h0000;
   logic [15:0] mem_word = 16'h0000;
   logic [15:0] w, r;
   logic [7:0] b;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 60342;
   int exp_st = 0;
   int n_wr = 0;
   int n0, t_rs, t_sd;

   always #12.5 core_clk = ~core_clk;

   sqr_host_model u_host (.core_clk(core_clk), .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid));

   sqr_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .acc(acc), .rd_data(rd_data),
      .rd_valid(rd_valid), .evt(evt), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
      .log_window_sel(log_window_sel), .restart_req(restart_req), .shutdown_req(shutdown_req),
      .config_locked(config_locked), .device_idle(device_idle), .use_last_good(use_last_good));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // memory side answers one cycle later; idle data toggles so a stale word never matches
   always @(posedge core_clk) begin
      cfg_rvalid <= cfg_rd;
      cfg_rdata <= cfg_rd ? mem_word : ~cfg_rdata;
      if (cfg_wr === 1'b1) begin
         n_wr <= n_wr + 1;
         last_w <= cfg_wdata;
      end
   end

   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   // status read against the model; the model then keeps only the stored-log flag
   task automatic read_status();
      logic [7:0] v;
      u_host.put_start(sqr_pkg::OFF_STATUS);
      u_host.get_rd(v);
      chk_val("status", 16'(exp_st), {8'h00, v});
      exp_st = exp_st & 8'h20;
   endtask : read_status

   task automatic watch_ctl(input logic [7:0] code);
      u_host.put_start(sqr_pkg::OFF_RESTART);
      u_host.put_wr(code);
      t_rs = -1;
      t_sd = -1;
      for (int i = 0; i < 2100; i++) begin
         if (restart_req === 1'b1 && t_rs < 0) t_rs = i;
         if (shutdown_req === 1'b1 && t_sd < 0) t_sd = i;
         @(posedge core_clk);
         #1;
      end
   endtask : watch_ctl

   task automatic close_out();
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      close_out();
   end

   initial begin
      evt.log_nonempty = 1'b1;
      repeat (20) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      exp_st = 8'h20;
      read_status();
      read_status();
      u_host.put_start(sqr_pkg::OFF_VERSION);
      u_host.get_rd(b);
      chk_val("revision", {8'h00, sqr_pkg::REV_MAJOR, sqr_pkg::REV_MINOR}, {8'h00, b});
      // one-cycle rail fault, then status, then the mask as the host is advised
      b = 8'($random(seed)) | 8'h01;
      evt.rail_fault = b;
      @(posedge core_clk);
      #1;
      evt.rail_fault = 8'h00;
      exp_st = exp_st | 8'h40;
      read_status();
      u_host.get_pair(sqr_pkg::OFF_RAIL_HIGH, w);
      chk_val("rail mask", {b, 8'h00}, w);
      u_host.put_start(sqr_pkg::OFF_RAIL_LOW);
      u_host.get_rd(b);
      chk_val("rail mask reread", 16'h0000, {8'h00, b});
      read_status();
      evt.fw_corrupt = 1'b1;
      evt.param_invalid = 1'b1;
      @(posedge core_clk);
      #1;
      evt.fw_corrupt = 1'b0;
      evt.param_invalid = 1'b0;
      exp_st = exp_st | 8'h18;
      chk_bit("device idle", 1'b1, device_idle);
      chk_bit("last good", 1'b1, use_last_good);
      read_status();
      // bad pointer, write to read-only, read of write-only, read beyond span
      for (int k = 0; k < 4; k++) begin
         if (k < 3) u_host.put_start(FAULT_OFF[k]);
         if (k == 1) u_host.put_wr(8'h5A);
         if (k == 2) u_host.get_rd(b);
         if (k == 3) u_host.get_pair(FAULT_OFF[k], w);
         if (k == 3) chk_val("beyond span", 16'h0000, {8'h00, w[15:8]});
         exp_st = exp_st | FAULT_ST[k];
         read_status();
      end
      read_status();
      evt.log_byte = 8'($random(seed));
      u_host.put_start(sqr_pkg::OFF_LOG_FIRST);
      u_host.get_rd(b);
      chk_val("log byte", {8'h00, evt.log_byte}, {8'h00, b});
      evt.log_empty = 1'b1;
      u_host.put_start(sqr_pkg::OFF_LOG_LAST);
      u_host.get_rd(b);
      chk_val("empty log", 16'h0000, {8'h00, b});
      // lock, then address and data through the window
      u_host.put_start(sqr_pkg::OFF_LOCK);
      u_host.put_wr(8'h01);
      u_host.put_start(sqr_pkg::OFF_LOCK);
      u_host.get_rd(b);
      chk_val("lock readback", 16'h0001, {8'h00, b});
      chk_bit("locked", 1'b1, config_locked);
      mem_word = 16'($random(seed));
      w = sqr_pkg::LOG_BASE + 16'($unsigned($random(seed)) % 48);
      u_host.put_word(sqr_pkg::OFF_WADDR_LOW, w);
      chk_bit("window fetch", 1'b1, cfg_rd);
      @(posedge core_clk);
      #1;
      chk_val("window address", w, cfg_addr);
      chk_bit("log window", 1'b1, log_window_sel);
      repeat (3) @(posedge core_clk);
      #1;
      u_host.get_pair(sqr_pkg::OFF_WDATA_LOW, r);
      chk_val("window read", mem_word, r);
      n0 = n_wr;
      u_host.put_word(sqr_pkg::OFF_WDATA_LOW, ~mem_word);
      repeat (3) @(posedge core_clk);
      #1;
      chk_val("locked writes", 16'(n0), 16'(n_wr));
      exp_st = exp_st | 8'h83;
      read_status();
      u_host.put_start(sqr_pkg::OFF_LOCK);
      u_host.put_wr(8'h00);
      chk_bit("unlocked", 1'b0, config_locked);
      r = 16'($random(seed));
      u_host.put_word(sqr_pkg::OFF_WDATA_LOW, r);
      repeat (3) @(posedge core_clk);
      #1;
      chk_val("memory writes", 16'(n0 + 1), 16'(n_wr));
      chk_val("memory word", r, last_w);
      u_host.put_word(sqr_pkg::OFF_WADDR_LOW, sqr_pkg::LOG_BASE + sqr_pkg::LOG_BYTES);
      @(posedge core_clk);
      #1;
      chk_bit("past log window", 1'b0, log_window_sel);
      read_status();
      watch_ctl(sqr_pkg::CMD_SHUTDOWN);
      chk_bit("shutdown", 1'b1, logic'(t_sd inside {0, 1} && t_rs < 0));
      watch_ctl(8'h01 + (8'($random(seed)) & 8'h7E));
      chk_bit("other code", 1'b1, logic'(t_sd < 0 && t_rs < 0));
      watch_ctl(sqr_pkg::CMD_RESTART);
      chk_bit("restart", 1'b1, logic'(t_rs inside {2000, 2001} && t_sd < 0));
      // second reset with an empty log drops the stored-log flag
      evt.log_nonempty = 1'b0;
      rst_n = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk_bit("idle after reset", 1'b0, device_idle);
      chk_bit("last good after reset", 1'b0, use_last_good);
      exp_st = 0;
      read_status();
      close_out();
   end
endmodule : testbench
`default_nettype wire
